// ===== rtl/apmc_defines.svh
/*
 * timing counts and encodings shared by the power mode controller.
 * assumes inclusion from the design file and the testbench.
 */
`ifndef APMC_DEFINES_SVH
`define APMC_DEFINES_SVH

// ==========================================================================
// power modes (control port code)
`define APMC_MODE_ON 2'h0
`define APMC_MODE_STBY 2'h1
`define APMC_MODE_PDN 2'h2

// ==========================================================================
// termination codes
`define APMC_TERM_100 2'h0
`define APMC_TERM_200 2'h1
`define APMC_TERM_HIZ 2'h2

// ==========================================================================
// width select codes
`define APMC_WIDTH_12 1'h0
`define APMC_WIDTH_16 1'h1

// ==========================================================================
// times in ns and derived cycle counts at 100 MHz
`define APMC_CLK_NS 10
`define APMC_CAL_NS 2000
`define APMC_CAL_CYC (`APMC_CAL_NS / `APMC_CLK_NS)
`define APMC_FG_CAL_NS 1000
`define APMC_FG_CAL_CYC (`APMC_FG_CAL_NS / `APMC_CLK_NS)

`endif

// ===== rtl/apmc_pkg.sv
/*
 * types for the power mode controller.
 * assumes apmc_defines.svh is on the include path.
 */
package apmc_pkg;

    typedef enum logic [2:0] {
        APMC_ST_STARTCAL = 3'h0,
        APMC_ST_ON = 3'h1,
        APMC_ST_STBY = 3'h3,
        APMC_ST_PDN = 3'h2,
        APMC_ST_RELOCK = 3'h6,
        APMC_ST_RECAL = 3'h7
    } apmc_state_e;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] term;
        logic width16;
        logic temp_en;
        logic [2:0] mixer_en;
        logic [3:0] lane_en;
    } apmc_cfg_s;

    typedef struct packed {
        logic ref_pwr;
        logic adc_pll_pwr;
        logic link_pll_pwr;
        logic adc_core_pwr;
        logic out_drv_pwr;
        logic other_pwr;
        logic digital_clk_en;
        logic framer_clk_en;
    } apmc_pwr_s;

endpackage

// ===== rtl/apmc_ctrl.sv
/*
 * power mode and configuration controller of the converter.
 * assumes a serial control port decoder that presents a whole configuration
 * word with a one-cycle write strobe only after the complete write, pll lock
 * inputs from the analog side, and a link partner reporting link ready.
 */
// ==========================================================================
`timescale 1ns/100ps
`include "apmc_defines.svh"

module apmc_ctrl #(
    parameter int MIXERS = 3,
    parameter int LANES = 4,
    parameter int CAL_CYC = `APMC_CAL_CYC,
    parameter int FG_CAL_CYC = `APMC_FG_CAL_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cfg_write,
    input wire apmc_pkg::apmc_cfg_s cfg_data,
    input wire logic adc_pll_locked,
    input wire logic link_pll_locked,
    input wire logic link_partner_ready,
    input wire logic overload,
    output apmc_pkg::apmc_pwr_s pwr,
    output logic [2:0] active_mode,
    output logic [MIXERS-1:0] mixer_clk_en,
    output logic [LANES-1:0] lane_pwr_en,
    output logic [1:0] term_sel,
    output logic trim_busy,
    output logic trim_done,
    output logic width16,
    output logic temperature_sense_output_en,
    output logic link_reinit_req,
    output logic data_valid,
    output logic decim_first,
    output logic conv_saturated
);

    // ======================================================================
    // state
    apmc_pkg::apmc_state_e state_reg;
    apmc_pkg::apmc_cfg_s cfg_reg;
    logic [15:0] cnt_reg;
    logic reinit_reg;
    logic ovl_reg;

    function automatic logic [15:0] cyc16(input int n);
        cyc16 = 16'(n);
    endfunction

    // ======================================================================
    // configuration latch, whole word only on the completed write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= '0;
        end else if (cfg_write) begin
            cfg_reg <= cfg_data;
        end
    end

    // ======================================================================
    // mode sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= apmc_pkg::APMC_ST_STARTCAL;
            cnt_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                apmc_pkg::APMC_ST_STARTCAL: begin
                    // foreground trim of termination and filter
                    if (cnt_reg == cyc16(FG_CAL_CYC - 1)) begin
                        state_reg <= apmc_pkg::APMC_ST_ON;
                        cnt_reg <= 16'h0000;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                apmc_pkg::APMC_ST_ON, apmc_pkg::APMC_ST_STBY: begin
                    if (cfg_reg.mode == `APMC_MODE_PDN) begin
                        state_reg <= apmc_pkg::APMC_ST_PDN;
                    end else if (cfg_reg.mode == `APMC_MODE_STBY) begin
                        state_reg <= apmc_pkg::APMC_ST_STBY;
                    end else begin
                        state_reg <= apmc_pkg::APMC_ST_ON;
                    end
                end
                apmc_pkg::APMC_ST_PDN: begin
                    if (cfg_reg.mode != `APMC_MODE_PDN) begin
                        state_reg <= apmc_pkg::APMC_ST_RELOCK;
                    end
                end
                apmc_pkg::APMC_ST_RELOCK: begin
                    if (adc_pll_locked && link_pll_locked) begin
                        state_reg <= apmc_pkg::APMC_ST_RECAL;
                        cnt_reg <= 16'h0000;
                    end
                end
                apmc_pkg::APMC_ST_RECAL: begin
                    if (cnt_reg == cyc16(CAL_CYC - 1)) begin
                        state_reg <= apmc_pkg::APMC_ST_ON;
                        cnt_reg <= 16'h0000;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                default: begin
                    state_reg <= apmc_pkg::APMC_ST_STARTCAL;
                    cnt_reg <= 16'h0000;
                end
            endcase
        end
    end

    // ======================================================================
    // link reinitialisation after standby
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reinit_reg <= 1'b0;
        end else if (state_reg == apmc_pkg::APMC_ST_STBY
                     && cfg_reg.mode == `APMC_MODE_ON) begin
            reinit_reg <= 1'b1;
        end else if (link_partner_ready) begin
            reinit_reg <= 1'b0;
        end
    end

    // ======================================================================
    // overload: saturation flag clears one sample after overload ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovl_reg <= 1'b0;
        end else begin
            ovl_reg <= overload;
        end
    end

    // ======================================================================
    // outputs
    logic is_on;
    logic is_stby;
    logic is_pdn;
    assign is_on = (state_reg == apmc_pkg::APMC_ST_ON);
    assign is_stby = (state_reg == apmc_pkg::APMC_ST_STBY);
    assign is_pdn = (state_reg == apmc_pkg::APMC_ST_PDN)
                    || (state_reg == apmc_pkg::APMC_ST_RELOCK);

    always_comb begin
        pwr.ref_pwr = 1'b1;
        pwr.adc_pll_pwr = 1'b1;
        pwr.link_pll_pwr = 1'b1;
        pwr.adc_core_pwr = !is_pdn;
        pwr.out_drv_pwr = !is_pdn;
        pwr.other_pwr = !is_pdn && !is_stby;
        pwr.digital_clk_en = is_on;
        pwr.framer_clk_en = is_on;
    end

    // one-hot mode indication: on, standby, power-down
    assign active_mode = {is_pdn || state_reg == apmc_pkg::APMC_ST_RECAL,
                          is_stby,
                          is_on || state_reg == apmc_pkg::APMC_ST_STARTCAL};

    assign mixer_clk_en = is_on ? cfg_reg.mixer_en[MIXERS-1:0]
                                : '0;
    assign lane_pwr_en = is_on ? cfg_reg.lane_en[LANES-1:0]
                               : '0;
    assign term_sel = (cfg_reg.term == 2'h3) ? `APMC_TERM_HIZ
                    : cfg_reg.term;
    assign trim_busy = (state_reg == apmc_pkg::APMC_ST_STARTCAL);
    assign trim_done = !trim_busy;
    assign width16 = cfg_reg.width16;
    assign temperature_sense_output_en = cfg_reg.temp_en;
    assign link_reinit_req = reinit_reg;
    assign data_valid = is_on && !reinit_reg;
    assign decim_first = 1'b1;
    assign conv_saturated = overload || ovl_reg;

    // ======================================================================
    // assertions
    sequence s_leave_pdn;
        state_reg == apmc_pkg::APMC_ST_PDN
        && cfg_reg.mode != `APMC_MODE_PDN;
    endsequence

    sequence s_relock;
        ##1 state_reg == apmc_pkg::APMC_ST_RELOCK;
    endsequence

    property p_pdn_relock;
        @(posedge clk) disable iff (!resetn)
        s_leave_pdn |-> s_relock;
    endproperty
    a_pdn_relock: assert property (p_pdn_relock)
        else $error("power-down release skipped relock");

    property p_relock_wait;
        @(posedge clk) disable iff (!resetn)
        (state_reg == apmc_pkg::APMC_ST_RELOCK
         && !(adc_pll_locked && link_pll_locked))
        |=> state_reg == apmc_pkg::APMC_ST_RELOCK;
    endproperty
    a_relock_wait: assert property (p_relock_wait)
        else $error("left relock without pll lock");

    property p_recal_no_data;
        @(posedge clk) disable iff (!resetn)
        state_reg == apmc_pkg::APMC_ST_RECAL |-> !data_valid;
    endproperty
    a_recal_no_data: assert property (p_recal_no_data)
        else $error("data valid during recalibration");

    property p_pdn_power;
        @(posedge clk) disable iff (!resetn)
        is_pdn |-> pwr.ref_pwr && pwr.adc_pll_pwr && pwr.link_pll_pwr
                   && !pwr.adc_core_pwr && !pwr.other_pwr;
    endproperty
    a_pdn_power: assert property (p_pdn_power)
        else $error("wrong power-down domains");

    property p_stby_gate;
        @(posedge clk) disable iff (!resetn)
        is_stby |-> pwr.adc_core_pwr && pwr.out_drv_pwr
                    && !pwr.digital_clk_en && !pwr.framer_clk_en;
    endproperty
    a_stby_gate: assert property (p_stby_gate)
        else $error("standby gating wrong");

    property p_stby_reinit;
        @(posedge clk) disable iff (!resetn)
        (is_stby && cfg_reg.mode == `APMC_MODE_ON)
        |=> link_reinit_req && !data_valid;
    endproperty
    a_stby_reinit: assert property (p_stby_reinit)
        else $error("no link reinit after standby");

    property p_ovl_recover;
        @(posedge clk) disable iff (!resetn)
        $fell(overload) |-> conv_saturated ##1 !conv_saturated || overload;
    endproperty
    a_ovl_recover: assert property (p_ovl_recover)
        else $error("overload recovery not one sample");

    property p_one_mode;
        @(posedge clk) disable iff (!resetn)
        $onehot(active_mode);
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("not exactly one mode");

    property p_mode_after_write;
        @(posedge clk) disable iff (!resetn)
        (is_on && cfg_reg.mode == `APMC_MODE_ON) |=> is_on;
    endproperty
    a_mode_after_write: assert property (p_mode_after_write)
        else $error("mode changed without a write");

    property p_startcal;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> trim_busy;
    endproperty
    a_startcal: assert property (p_startcal)
        else $error("no startup calibration");

    property p_cfg_hold;
        @(posedge clk) disable iff (!resetn)
        !cfg_write |=> $stable(cfg_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without a write");

    property p_on_power;
        @(posedge clk) disable iff (!resetn)
        is_on |-> pwr.adc_core_pwr && pwr.out_drv_pwr && pwr.other_pwr
                  && pwr.digital_clk_en && pwr.framer_clk_en;
    endproperty
    a_on_power: assert property (p_on_power)
        else $error("block unpowered in power-on mode");

    property p_mixer_gate;
        @(posedge clk) disable iff (!resetn)
        (mixer_clk_en & ~cfg_reg.mixer_en[MIXERS-1:0]) == '0
        && (is_on || mixer_clk_en == '0);
    endproperty
    a_mixer_gate: assert property (p_mixer_gate)
        else $error("disabled mixer pair still clocked");

    property p_lane_gate;
        @(posedge clk) disable iff (!resetn)
        (lane_pwr_en & ~cfg_reg.lane_en[LANES-1:0]) == '0
        && (is_on || lane_pwr_en == '0);
    endproperty
    a_lane_gate: assert property (p_lane_gate)
        else $error("unused lane still powered");

    property p_term_legal;
        @(posedge clk) disable iff (!resetn)
        term_sel == `APMC_TERM_100 || term_sel == `APMC_TERM_200
        || term_sel == `APMC_TERM_HIZ;
    endproperty
    a_term_legal: assert property (p_term_legal)
        else $error("termination code outside the three settings");

    property p_recal_len;
        @(posedge clk) disable iff (!resetn)
        (state_reg == apmc_pkg::APMC_ST_RECAL
         && cnt_reg != cyc16(CAL_CYC - 1))
        |=> state_reg == apmc_pkg::APMC_ST_RECAL;
    endproperty
    a_recal_len: assert property (p_recal_len)
        else $error("recalibration cut short");

    property p_startcal_len;
        @(posedge clk) disable iff (!resetn)
        (state_reg == apmc_pkg::APMC_ST_STARTCAL
         && cnt_reg != cyc16(FG_CAL_CYC - 1))
        |=> trim_busy;
    endproperty
    a_startcal_len: assert property (p_startcal_len)
        else $error("startup calibration cut short");

    property p_width_temp;
        @(posedge clk) disable iff (!resetn)
        cfg_write |=> width16 == $past(cfg_data.width16)
            && temperature_sense_output_en == $past(cfg_data.temp_en);
    endproperty
    a_width_temp: assert property (p_width_temp)
        else $error("width or temperature routing not taken");

endmodule

// ===== verification/apmc_partner.sv
/*
 * behavioural far side: pll lock indicators and link partner.
 * assumes the testbench raises lose_lock while plls must relock.
 */
`timescale 1ns/100ps
// ==========================================================================
// pll and link partner model
module apmc_partner #(
    parameter int LOCK_CYC = 6,
    parameter int READY_CYC = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic lose_lock,
    input wire logic link_reinit_req,
    output logic adc_pll_locked,
    output logic link_pll_locked,
    output logic link_partner_ready
);
    int lock_cnt;
    int rdy_cnt;
    // relock some cycles after the loss ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_cnt <= 0;
        end else if (lose_lock) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_CYC) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    assign adc_pll_locked = (lock_cnt >= LOCK_CYC);
    assign link_pll_locked = (lock_cnt >= LOCK_CYC - 1);
    // far end finishes link bring-up after a delay
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdy_cnt <= 0;
        end else if (!link_reinit_req) begin
            rdy_cnt <= 0;
        end else if (rdy_cnt < READY_CYC) begin
            rdy_cnt <= rdy_cnt + 1;
        end
    end
    assign link_partner_ready = (rdy_cnt >= READY_CYC);
endmodule

// ===== verification/testbench.sv
/*
 * self-checking bench of the power mode controller.
 * assumes apmc_pkg and the controller are compiled first.
 */
`timescale 1ns/100ps
`include "apmc_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    n_errors++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
// ==========================================================================
// top
module testbench;
    logic clk, resetn, cfg_write, overload, lose_lock;
    logic adc_lk, link_lk, p_rdy;
    apmc_pkg::apmc_cfg_s cfg_data;
    apmc_pkg::apmc_pwr_s pwr;
    logic [2:0] active_mode, mixer_clk_en;
    logic [3:0] lane_pwr_en;
    logic [1:0] term_sel;
    logic trim_busy, trim_done, width16, temp_out_en, reinit, data_valid;
    logic decim_first, conv_saturated;
    int n_errors = 0;
    int num_checks = 0;
    apmc_ctrl #(.CAL_CYC(4), .FG_CAL_CYC(4)) apmc_ctrl_i (.clk(clk),
        .resetn(resetn), .cfg_write(cfg_write), .cfg_data(cfg_data),
        .adc_pll_locked(adc_lk), .link_pll_locked(link_lk),
        .link_partner_ready(p_rdy), .overload(overload), .pwr(pwr),
        .active_mode(active_mode), .mixer_clk_en(mixer_clk_en),
        .lane_pwr_en(lane_pwr_en), .term_sel(term_sel),
        .trim_busy(trim_busy), .trim_done(trim_done), .width16(width16),
        .temperature_sense_output_en(temp_out_en),
        .link_reinit_req(reinit), .data_valid(data_valid),
        .decim_first(decim_first), .conv_saturated(conv_saturated));
    apmc_partner apmc_partner_i (.clk(clk), .resetn(resetn),
        .lose_lock(lose_lock), .link_reinit_req(reinit),
        .adc_pll_locked(adc_lk), .link_pll_locked(link_lk),
        .link_partner_ready(p_rdy));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one whole write, outputs settle two edges later
    task automatic wr(input logic [1:0] md, input logic [1:0] tm,
        input logic w16, input logic ten);
        @(posedge clk);
        #1 cfg_write = 1'h1;
        cfg_data = '{md, tm, w16, ten, 3'h5 ^ {1'h0, tm}, 4'h9 ^ {2'h0, tm}};
        cyc(1);
        cfg_write = 1'h0;
        cyc(2);
    endtask
    task automatic wait_valid(output int n);
        n = 0;
        while (data_valid !== 1'h1 && n < 60) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_startup();
        `CHK("trim_busy", 1'h1, trim_busy)
        cyc(8);
        `CHK("trim_done", 1'h1, trim_done)
        `CHK("pwr_on", 8'hff, pwr)
        `CHK("mode_on", 3'h1, active_mode)
        `CHK("decim", 1'h1, decim_first)
    endtask
    task automatic t_config();
        logic [1:0] ex_t;
        for (int t = 0; t < 4; t++) begin
            wr(`APMC_MODE_ON, t[1:0], t[0], ~t[0]);
            ex_t = (t == 3) ? `APMC_TERM_HIZ : t[1:0];
            `CHK("term", ex_t, term_sel)
            `CHK("width", t[0], width16)
            `CHK("temp", ~t[0], temp_out_en)
            `CHK("mixer", 3'h5 ^ {1'h0, t[1:0]}, mixer_clk_en)
            `CHK("lane", 4'h9 ^ {2'h0, t[1:0]}, lane_pwr_en)
        end
    endtask
    task automatic t_pdn();
        int n;
        wr(`APMC_MODE_PDN, 2'h0, 1'h0, 1'h0);
        lose_lock = 1'h1;
        `CHK("pwr_pdn", 8'he0, pwr)
        `CHK("mode_pdn", 3'h4, active_mode)
        `CHK("lane_pdn", 4'h0, lane_pwr_en)
        wr(`APMC_MODE_ON, 2'h0, 1'h0, 1'h0);
        cyc(3);
        `CHK("valid_lock", 1'h0, data_valid)
        lose_lock = 1'h0;
        wait_valid(n);
        `CHK("relock_cal", 1'h1, n >= 10)
        `CHK("pwr_back", 8'hff, pwr)
    endtask
    task automatic t_stby();
        int n;
        logic [4:0] kept;
        wr(`APMC_MODE_STBY, 2'h0, 1'h0, 1'h0);
        `CHK("mode_stby", 3'h2, active_mode)
        kept = {pwr.adc_core_pwr, pwr.adc_pll_pwr, pwr.link_pll_pwr,
            pwr.out_drv_pwr, pwr.digital_clk_en};
        `CHK("pwr_kept", 5'h1e, kept)
        `CHK("clk_gate", 2'h0, {pwr.digital_clk_en, pwr.framer_clk_en})
        wr(`APMC_MODE_ON, 2'h0, 1'h0, 1'h0);
        `CHK("reinit", 1'h1, reinit)
        `CHK("valid_wait", 1'h0, data_valid)
        wait_valid(n);
        `CHK("partner_rdy", 1'h1, p_rdy)
        `CHK("reinit_clr", 1'h0, reinit)
    endtask
    task automatic t_overload();
        overload = 1'h1;
        cyc(3);
        `CHK("sat", 1'h1, conv_saturated)
        overload = 1'h0;
        #1;
        `CHK("sat_tail", 1'h1, conv_saturated)
        cyc(1);
        `CHK("recover", 1'h0, conv_saturated)
    endtask
    initial begin
        resetn = 1'h0;
        cfg_write = 1'h0;
        cfg_data = '0;
        overload = 1'h0;
        lose_lock = 1'h0;
        cyc(4);
        resetn = 1'h1;
        t_startup();
        t_config();
        t_pdn();
        t_stby();
        t_overload();
        end_sim();
    end
    initial begin
        #(3000 * 10);
        n_errors++;
        end_sim();
    end
endmodule
